// ===== inc/crf_pkg.sv
`default_nettype none
package crf_pkg;
    // ==========================================
    // sizes
    localparam int CRF_NBUF = 5;
    localparam int CRF_NBYTE = 15;
    localparam int CRF_NFLT = 8;
    localparam logic [2:0] CRF_FULL = 3'h5;
    // ==========================================
    // register byte addresses
    localparam logic [7:0] CRF_OFS_CTL0 = 8'h00;
    localparam logic [7:0] CRF_OFS_CTL1 = 8'h04;
    localparam logic [7:0] CRF_OFS_BTR0 = 8'h08;
    localparam logic [7:0] CRF_OFS_BTR1 = 8'h0c;
    localparam logic [7:0] CRF_OFS_RFLG = 8'h10;
    localparam logic [7:0] CRF_OFS_RIER = 8'h14;
    localparam logic [7:0] CRF_OFS_IDAC = 8'h18;
    localparam logic [7:0] CRF_OFS_RXERR = 8'h1c;
    localparam logic [7:0] CRF_OFS_TXERR = 8'h20;
    // windows: patterns 0x40 and masks 0x60 by paddr[7:5], head buffer 0x80 by paddr[7:6]
    localparam logic [2:0] CRF_WIN_PAT = 3'h2;
    localparam logic [2:0] CRF_WIN_MSK = 3'h3;
    localparam logic [1:0] CRF_WIN_FG = 2'h2;
    // ==========================================
    // field positions
    localparam int CRF_B_INIT_REQUEST = 0;
    localparam int CRF_B_INIT_ACKNOWLEDGE = 0;
    localparam int CRF_B_LOOP = 5;
    localparam int CRF_B_ENABLE = 7;
    localparam int CRF_B_RXF = 0;
    localparam int CRF_B_OVR = 1;
    localparam int CRF_B_AM = 4;
    localparam int CRF_B_IDE = 3;
    localparam int CRF_IDR1 = 1;
    localparam logic CRF_RECESSIVE = 1'b1;
    // ==========================================
    // types
    typedef enum logic [1:0] {
        CRF_AM_TWO = 2'h0,
        CRF_AM_FOUR = 2'h1,
        CRF_AM_EIGHT = 2'h2,
        CRF_AM_CLOSED = 2'h3
    } crf_am_type;
    typedef enum logic [3:0] {
        CRF_RUN = 4'h1,
        CRF_REQ_BUS = 4'h2,
        CRF_REQ_CAN = 4'h4,
        CRF_INIT = 4'h8
    } crf_init_type;
    typedef logic [CRF_NBYTE-1:0][7:0] crf_buf_type;
    typedef struct packed {
        logic we;
        logic [3:0] sel;
        logic [7:0] data;
        logic eof;
        logic good;
        logic own;
    } crf_rx_type;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        crf_init_type init_st;
        logic init_request;
        logic module_enable_bit;
        logic en_written;
        logic loopback;
        logic [7:0] btr0;
        logic [7:0] btr1;
        crf_am_type idam;
        logic rx_ie;
        logic ovr_ie;
        logic ovr_flag;
        logic [CRF_NFLT-1:0][7:0] pat;
        logic [CRF_NFLT-1:0][7:0] msk;
        crf_buf_type bg;
        crf_buf_type [CRF_NBUF-1:0] fifo;
        logic [CRF_NBUF-1:0][2:0] hit;
        logic [2:0] wr_ptr;
        logic [2:0] rd_ptr;
        logic [2:0] count;
        logic txd;
        logic rx_irq;
        logic ovr_irq;
    } crf_state_type;
endpackage
`default_nettype wire

// ===== logic/crf_rx_filter.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - accepted frames queue in a five-entry fifo seen through one window.
// - every receive buffer holds fifteen bytes of control, id, data, stamp.
// - background buffer is private; software reads only the head entry.
// - receive-full flag is set while the head holds an accepted good frame.
// - incoming bytes land in the background buffer while the filter checks them.
// - good accepted frame enters fifo, sets full flag, raises unmasked interrupt.
// - a new frame may arrive right after the interframe space.
// - failed or rejected frames are not queued; background gets overwritten.
// - own transmitted frames are not queued unless loopback is on.
// - after lost arbitration the winning frame is received normally.
// - accepted frame with fifo full is dropped and overrun is flagged.
// - while full, transmit goes on; reception resumes once an entry frees.
// - pattern registers give id values; masks mark bits as ignored.
// - three-bit hit index reports the lowest-numbered matching filter.
// - two-filter mode compares full ids per 32-bit bank, hits 0 and 1.
// - four-filter mode compares sixteen bits per filter, hits 0 to 3.
// - eight-filter mode compares first id byte per filter, hits 0 to 7.
// - closed mode never queues a frame nor sets the full flag.
// - error counters ignore every software write.
// - configuration registers accept writes only in acknowledged init mode.
// - transmit pin goes recessive at once in power-down or init.
// - module enable bit is writable once after reset in normal modes.
// - init acknowledge rises only after all stages reached init.
module crf_rx_filter
    import crf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire crf_rx_type rx_in,
    input wire logic tx_bit,
    input wire logic power_down,
    input wire logic special_mode,
    input wire logic [7:0] rx_err_cnt,
    input wire logic [7:0] tx_err_cnt,
    output logic bus_transmit_pin,
    output logic rx_irq,
    output logic overrun_irq,
    output logic [15:0] bit_timing
);

    // ==========================================
    // helpers
    // mask semantics
    function automatic logic byte_ok(input logic [7:0] a, input logic [7:0] p,
                                     input logic [7:0] m);
        return ((a ^ p) & ~m) == 8'h00;
    endfunction

    // ring of five entries, pointers wrap after the last
    function automatic logic [2:0] ptr_next(input logic [2:0] p);
        return (p == CRF_FULL - 3'h1) ? 3'h0 : p + 3'h1;
    endfunction

    crf_state_type s_q;
    crf_state_type s_d;

    logic [CRF_NFLT-1:0] match_w;
    logic [2:0] hit_idx_w;
    logic any_hit_w;
    logic in_init_w;
    logic cfg_ok_w;
    logic wr_w;
    logic setup_w;
    logic pop_w;
    logic accept_w;
    logic push_w;
    logic full_w;
    logic rx_full_flag;
    logic ide_w;

    assign in_init_w = s_q.init_st == CRF_INIT;
    // lock opens only with request and acknowledge both set
    assign cfg_ok_w = s_q.init_request & in_init_w;
    assign setup_w = psel & ~penable;
    assign wr_w = psel & penable & pwrite & s_q.pready;
    assign rx_full_flag = s_q.count != 3'h0;
    assign full_w = s_q.count == CRF_FULL;
    // release of the head comes from a software write of one
    assign pop_w = wr_w & (paddr == CRF_OFS_RFLG) & pwdata[CRF_B_RXF] & rx_full_flag;
    assign ide_w = s_q.bg[CRF_IDR1][CRF_B_IDE];

    // ==========================================
    // acceptance filter, evaluated on the background buffer
    always_comb begin
        match_w = '0;
        unique case (s_q.idam)
            CRF_AM_TWO: begin
                // 32-bit banks, extended frames use all four id bytes
                for (int k = 0; k < 2; k++) begin
                    match_w[k] = byte_ok(s_q.bg[0], s_q.pat[4*k], s_q.msk[4*k]) &
                        byte_ok(s_q.bg[1], s_q.pat[4*k+1], s_q.msk[4*k+1]) &
                        (~ide_w |
                        (byte_ok(s_q.bg[2], s_q.pat[4*k+2], s_q.msk[4*k+2]) &
                        byte_ok(s_q.bg[3], s_q.pat[4*k+3], s_q.msk[4*k+3])));
                end
            end
            CRF_AM_FOUR: begin
                for (int k = 0; k < 4; k++) begin
                    match_w[k] = byte_ok(s_q.bg[0], s_q.pat[2*k], s_q.msk[2*k]) &
                        byte_ok(s_q.bg[1], s_q.pat[2*k+1], s_q.msk[2*k+1]);
                end
            end
            CRF_AM_EIGHT: begin
                // 8-bit filters on the first id byte
                for (int k = 0; k < CRF_NFLT; k++) begin
                    match_w[k] = byte_ok(s_q.bg[0], s_q.pat[k], s_q.msk[k]);
                end
            end
            CRF_AM_CLOSED: begin
                match_w = '0;
            end
        endcase
    end

    always_comb begin
        hit_idx_w = 3'h0;
        for (int k = CRF_NFLT - 1; k >= 0; k--) begin
            if (match_w[k]) begin
                hit_idx_w = 3'(k);
            end
        end
    end
    assign any_hit_w = |match_w;

    // only a good, matching frame counts
    // own frames skipped unless looped back
    // after lost arbitration the engine reports the frame as foreign
    assign accept_w = rx_in.eof & rx_in.good & any_hit_w & (~rx_in.own | s_q.loopback) &
        (s_q.init_st == CRF_RUN) & ~s_q.init_request & s_q.module_enable_bit & ~power_down;
    // an entry freed in the same cycle makes room
    assign push_w = accept_w & (~full_w | pop_w);

    // ==========================================
    // next state
    always_comb begin
        logic [4:0] idx;
        logic [7:0] rd;
        logic mapped;
        s_d = s_q;
        idx = paddr[6:2];
        rd = 8'h00;
        mapped = 1'b1;

        // apb: one wait-free access phase after each setup
        s_d.pready = setup_w;
        s_d.pslverr = 1'b0;
        unique case (paddr)
            CRF_OFS_CTL0: rd[CRF_B_INIT_REQUEST] = s_q.init_request;
            CRF_OFS_CTL1: begin
                rd[CRF_B_ENABLE] = s_q.module_enable_bit;
                rd[CRF_B_LOOP] = s_q.loopback;
                rd[CRF_B_INIT_ACKNOWLEDGE] = in_init_w;
            end
            CRF_OFS_BTR0: rd = s_q.btr0;
            CRF_OFS_BTR1: rd = s_q.btr1;
            CRF_OFS_RFLG: begin
                // full flag mirrors a non-empty queue
                rd[CRF_B_RXF] = rx_full_flag;
                rd[CRF_B_OVR] = s_q.ovr_flag;
            end
            CRF_OFS_RIER: begin
                rd[CRF_B_RXF] = s_q.rx_ie;
                rd[CRF_B_OVR] = s_q.ovr_ie;
            end
            CRF_OFS_IDAC: begin
                rd[CRF_B_AM +: 2] = s_q.idam;
                rd[2:0] = s_q.hit[s_q.rd_ptr];
            end
            CRF_OFS_RXERR: rd = rx_err_cnt;
            CRF_OFS_TXERR: rd = tx_err_cnt;
            default: begin
                if (paddr[7:5] == CRF_WIN_PAT) begin
                    rd = s_q.pat[paddr[4:2]];
                end else if (paddr[7:5] == CRF_WIN_MSK) begin
                    rd = s_q.msk[paddr[4:2]];
                end else if (paddr[7:6] == CRF_WIN_FG && idx < 5'(CRF_NBYTE)) begin
                    // only the head entry is visible
                    rd = s_q.fifo[s_q.rd_ptr][idx[3:0]];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
        if (setup_w) begin
            s_d.prdata = {24'h000000, rd};
            s_d.pslverr = ~mapped;
        end

        // register writes; error counters have no write path at all
        // counters are inputs only
        if (wr_w) begin
            unique case (paddr)
                CRF_OFS_CTL0: begin
                    // request may only drop once acknowledged
                    if (pwdata[CRF_B_INIT_REQUEST] | in_init_w) begin
                        s_d.init_request = pwdata[CRF_B_INIT_REQUEST];
                    end
                end
                CRF_OFS_CTL1: begin
                    // enable writable once unless special mode
                    if (~s_q.en_written | special_mode) begin
                        s_d.module_enable_bit = pwdata[CRF_B_ENABLE];
                        s_d.en_written = 1'b1;
                    end
                    if (cfg_ok_w) begin
                        s_d.loopback = pwdata[CRF_B_LOOP];
                    end
                end
                CRF_OFS_BTR0: begin
                    if (cfg_ok_w) begin
                        s_d.btr0 = pwdata[7:0];
                    end
                end
                CRF_OFS_BTR1: begin
                    if (cfg_ok_w) begin
                        s_d.btr1 = pwdata[7:0];
                    end
                end
                CRF_OFS_RFLG: begin
                    if (pwdata[CRF_B_OVR]) begin
                        s_d.ovr_flag = 1'b0;
                    end
                end
                CRF_OFS_RIER: begin
                    s_d.rx_ie = pwdata[CRF_B_RXF];
                    s_d.ovr_ie = pwdata[CRF_B_OVR];
                end
                CRF_OFS_IDAC: begin
                    if (cfg_ok_w) begin
                        s_d.idam = crf_am_type'(pwdata[CRF_B_AM +: 2]);
                    end
                end
                default: begin
                    if (cfg_ok_w && paddr[7:5] == CRF_WIN_PAT) begin
                        s_d.pat[paddr[4:2]] = pwdata[7:0];
                    end
                    if (cfg_ok_w && paddr[7:5] == CRF_WIN_MSK) begin
                        s_d.msk[paddr[4:2]] = pwdata[7:0];
                    end
                end
            endcase
        end

        // an index past the fifteenth byte is dropped
        // bytes go straight into the background buffer
        if (rx_in.we && rx_in.sel < 4'(CRF_NBYTE) && s_q.init_st == CRF_RUN) begin
            s_d.bg[rx_in.sel] = rx_in.data;
        end

        // accepted frame moves into the queue
        if (push_w) begin
            s_d.fifo[s_q.wr_ptr] = s_q.bg;
            s_d.hit[s_q.wr_ptr] = hit_idx_w;
            s_d.wr_ptr = ptr_next(s_q.wr_ptr);
        end
        if (pop_w) begin
            s_d.rd_ptr = ptr_next(s_q.rd_ptr);
        end
        s_d.count = s_q.count + {2'b00, push_w} - {2'b00, pop_w};
        // full queue drops the frame; set beats a same-cycle clear
        if (accept_w && full_w && !pop_w) begin
            s_d.ovr_flag = 1'b1;
        end

        // request walks through both stages before acknowledge
        unique case (s_q.init_st)
            CRF_RUN: begin
                if (s_q.init_request) begin
                    s_d.init_st = CRF_REQ_BUS;
                end
            end
            CRF_REQ_BUS: s_d.init_st = CRF_REQ_CAN;
            CRF_REQ_CAN: s_d.init_st = CRF_INIT;
            CRF_INIT: begin
                if (!s_d.init_request) begin
                    s_d.init_st = CRF_RUN;
                end
            end
        endcase
        // init mode returns flags, enables and queue to defaults
        if (in_init_w) begin
            s_d.count = 3'h0;
            s_d.wr_ptr = 3'h0;
            s_d.rd_ptr = 3'h0;
            s_d.ovr_flag = 1'b0;
            s_d.rx_ie = 1'b0;
            s_d.ovr_ie = 1'b0;
        end

        // recessive as soon as init is requested or power is down
        s_d.txd = (s_d.init_request | in_init_w | power_down | ~s_q.module_enable_bit) ?
            CRF_RECESSIVE : tx_bit;
        s_d.rx_irq = s_d.rx_ie & (s_d.count != 3'h0);
        s_d.ovr_irq = s_d.ovr_ie & s_d.ovr_flag;
    end

    // ==========================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.init_st <= CRF_RUN;
            s_q.init_request <= 1'b1;
            s_q.idam <= CRF_AM_TWO;
            s_q.txd <= CRF_RECESSIVE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign bus_transmit_pin = s_q.txd;
    assign rx_irq = s_q.rx_irq;
    assign overrun_irq = s_q.ovr_irq;
    assign bit_timing = {s_q.btr1, s_q.btr0};

    // ==========================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_fifo_bound: assert property (s_q.count <= CRF_FULL)
        else $error("fifo count above five");
    a_push_sets_full: assert property (push_w |=> rx_full_flag)
        else $error("accepted frame did not set full flag");
    a_push_irq: assert property (push_w && s_q.rx_ie && !wr_w |=> rx_irq)
        else $error("receive interrupt missing");
    a_closed_no_push: assert property (
        s_q.idam == CRF_AM_CLOSED && !pop_w && !in_init_w |=> s_q.count == $past(s_q.count))
        else $error("closed filter queued a frame");
    a_own_frame_drop: assert property (
        rx_in.eof && rx_in.own && !s_q.loopback && !pop_w && !in_init_w
        |=> s_q.count == $past(s_q.count))
        else $error("own frame queued");
    a_overrun_flag: assert property (
        accept_w && full_w && !pop_w |=> s_q.ovr_flag && s_q.count == CRF_FULL)
        else $error("overrun not flagged");
    a_hit_stored: assert property (
        push_w |=> s_q.hit[$past(s_q.wr_ptr)] == $past(hit_idx_w))
        else $error("hit index not stored");
    a_lock_timing: assert property (
        wr_w && paddr == CRF_OFS_BTR0 && !cfg_ok_w |=> $stable(s_q.btr0))
        else $error("locked register written");
    a_tx_recessive: assert property (
        s_q.init_request || power_down |=> bus_transmit_pin == CRF_RECESSIVE)
        else $error("transmit pin not recessive");
    a_enable_once: assert property (
        wr_w && paddr == CRF_OFS_CTL1 && s_q.en_written && !special_mode
        |=> $stable(s_q.module_enable_bit))
        else $error("enable bit written twice");
    // release edge still holds reset state, so the walk starts one edge later
    a_init_ack_delay: assert property (
        presetn && s_q.init_st == CRF_RUN && s_q.init_request |-> !in_init_w ##3 in_init_w)
        else $error("init acknowledge timing wrong");

    c_push: cover property (push_w);
    c_overrun: cover property (accept_w && full_w && !pop_w);
    c_pop: cover property (pop_w);
    c_init: cover property ($rose(in_init_w));

endmodule
`default_nettype wire

// ===== tb/crf_can_node.sv
`timescale 1ns/1ps
`default_nettype none
module crf_can_node
    import crf_pkg::*;
(
    input wire logic pclk,
    output var crf_rx_type rx_in
);
    initial rx_in = '0;
    // ==========================================
    // frame sender
    // back to back
    task automatic send(input logic [7:0] id0, input logic [7:0] tag, input logic good,
                        input logic own);
        logic [7:0] b;
        b = 8'h00;
        for (int j = 0; j < CRF_NBYTE; j++) begin
            b = (j == 0) ? id0 : (j == 1) ? 8'h60 : (j == 4) ? tag : 8'(j);
            @(posedge pclk);
            rx_in.we <= 1'b1;
            rx_in.sel <= 4'(j);
            rx_in.data <= b;
        end
        @(posedge pclk);
        rx_in.we <= 1'b0;
        // byte lane no longer valid: show the inverse, not the last byte
        rx_in.data <= ~b;
        rx_in.eof <= 1'b1;
        rx_in.good <= good;
        rx_in.own <= own;
        @(posedge pclk);
        rx_in.eof <= 1'b0;
        rx_in.data <= b ^ 8'h5a;
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import crf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    crf_rx_type rx_in;
    logic tx_bit = 1'b1;
    logic power_down = 1'b0;
    logic special_mode = 1'b0;
    logic [7:0] rx_err_cnt = 8'h3c;
    logic [7:0] tx_err_cnt = 8'hc3;
    logic bus_transmit_pin;
    logic rx_irq;
    logic overrun_irq;
    logic [15:0] bit_timing;
    int n_fail = 0;
    int compares = 0;
    logic [31:0] rd;
    logic err;
    // queued flag in bit 3, expected hit below it
    logic [3:0] hit_exp [4] = '{4'h9, 4'ha, 4'hc, 4'h0};
    logic [3:0] miss_exp [4] = '{4'h0, 4'h0, 4'he, 4'h0};

    always #5 pclk = ~pclk;

    crf_rx_filter i_crf_rx_filter (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
        .tx_bit(tx_bit), .power_down(power_down), .special_mode(special_mode),
        .rx_err_cnt(rx_err_cnt), .tx_err_cnt(tx_err_cnt),
        .bus_transmit_pin(bus_transmit_pin), .rx_irq(rx_irq),
        .overrun_irq(overrun_irq), .bit_timing(bit_timing));
    crf_can_node i_crf_can_node (.pclk(pclk), .rx_in(rx_in));

    // ==========================================
    // report and bus tasks
    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // pready is registered, so its level before the edge is what the edge samples
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            n_fail++;
            $display("[FAIL] %0t apb wait timed out", $time);
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic set_init(input logic v);
        int n;
        apb(1'b1, CRF_OFS_CTL0, {31'h0, v});
        for (n = 0; n < 20; n++) begin
            apb(1'b0, CRF_OFS_CTL1, 32'h0);
            if (rd[0] === v) break;
        end
        chk({31'h0, rd[0]}, {31'h0, v});
        if (n == 20) begin
            end_sim();
        end
    endtask
    task automatic chk_rx(input logic [3:0] e);
        rdc(CRF_OFS_RFLG, 32'h1, {31'h0, e[3]});
        chk({31'h0, rx_irq}, {31'h0, e[3]});
        if (e[3]) begin
            rdc(CRF_OFS_IDAC, 32'h7, {29'h0, e[2:0]});
            apb(1'b1, CRF_OFS_RFLG, 32'h1);
        end
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        chk({bit_timing, 15'h0, bus_transmit_pin}, 32'h1);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        set_init(1'b1);
        chk({31'h0, bus_transmit_pin}, 32'h1);
        apb(1'b1, CRF_OFS_CTL1, 32'h80);
        apb(1'b1, CRF_OFS_BTR0, 32'h5a);
        apb(1'b1, CRF_OFS_BTR1, 32'ha5);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'h40 + 8'(4 * i), 32'((i + 1) * 16));
            apb(1'b1, 8'h60 + 8'(4 * i), (i == 4) ? 32'h0f : (i == 6) ? 32'hff : 32'h0);
        end
        chk({16'h0, bit_timing}, 32'ha55a);
        apb(1'b1, CRF_OFS_RXERR, 32'h0);
        rdc(CRF_OFS_RXERR, 32'hff, 32'h3c);
        rdc(CRF_OFS_TXERR, 32'hff, 32'hc3);
        apb(1'b0, 8'h3c, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // every filter mode, with hit, miss, bad and own frames
        for (int m = 0; m < 4; m++) begin
            set_init(1'b1);
            apb(1'b1, CRF_OFS_IDAC, 32'(m) << 4);
            set_init(1'b0);
            // init clears the enables, so they are set once running
            apb(1'b1, CRF_OFS_RIER, 32'h3);
            i_crf_can_node.send(8'h5a, 8'h00, 1'b1, 1'b0);
            chk_rx(hit_exp[m]);
            i_crf_can_node.send(8'h4a, 8'h00, 1'b1, 1'b0);
            chk_rx(miss_exp[m]);
            i_crf_can_node.send(8'h5a, 8'h00, 1'b0, 1'b0);
            chk_rx(4'h0);
            i_crf_can_node.send(8'h5a, 8'h00, 1'b1, 1'b1);
            chk_rx(4'h0);
        end
        apb(1'b1, CRF_OFS_BTR0, 32'h0);
        rdc(CRF_OFS_BTR0, 32'hff, 32'h5a);
        apb(1'b1, CRF_OFS_IDAC, 32'h0);
        rdc(CRF_OFS_IDAC, 32'h30, 32'h30);
        tx_bit <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({31'h0, bus_transmit_pin}, 32'h0);
        power_down <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({31'h0, bus_transmit_pin}, 32'h1);
        power_down <= 1'b0;
        // fill the queue past full, loopback on; tx still low, init must force recessive
        set_init(1'b1);
        chk({31'h0, bus_transmit_pin}, 32'h1);
        tx_bit <= 1'b1;
        apb(1'b1, CRF_OFS_IDAC, 32'h0);
        apb(1'b1, CRF_OFS_CTL1, 32'h20);
        rdc(CRF_OFS_CTL1, 32'ha0, 32'ha0);
        set_init(1'b0);
        apb(1'b1, CRF_OFS_RIER, 32'h3);
        for (int k = 0; k < 6; k++) begin
            i_crf_can_node.send(8'h5a, 8'(k), 1'b1, k == 0);
        end
        rdc(CRF_OFS_RFLG, 32'h3, 32'h3);
        chk({31'h0, overrun_irq}, 32'h1);
        rdc(8'h90, 32'hff, 32'h00);
        apb(1'b1, CRF_OFS_RFLG, 32'h1);
        i_crf_can_node.send(8'h5a, 8'h06, 1'b1, 1'b0);
        for (int j = 0; j < 5; j++) begin
            rdc(8'h90, 32'hff, (j < 4) ? 32'(j + 1) : 32'h6);
            rdc(8'hb8, 32'hff, 32'h0e);
            apb(1'b1, CRF_OFS_RFLG, 32'h1);
        end
        rdc(CRF_OFS_RFLG, 32'h1, 32'h0);
        apb(1'b1, CRF_OFS_RFLG, 32'h2);
        repeat (2) @(posedge pclk);
        chk({30'h0, overrun_irq, rx_irq}, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
